// file: design/drc_pkg.sv
// Purpose: shared constants, state codes and address helpers of the strobe DRAM host
// Assumes: mclk at 100 MHz; figures are those of the fastest speed grade
// Notes:   times stay in their own units, cycle counts are derived from them
package drc_pkg;
    localparam int CLK_NS = 10;

    // least time: round up, never below one cycle
    function automatic int cyc_min(input int ns);
        return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int cyc_max(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int ADDR_W      = 16;
    localparam int HALF_W      = 8;
    localparam int ROW_LSB     = 8;
    localparam int REF_ROWS    = 256;
    localparam int INIT_CYCLES = 8;

    // times as printed
    localparam int T_RAC_NS     = 120;
    localparam int T_CAC_NS     = 70;
    localparam int T_RAS_NS     = 120;
    localparam int T_RAS_MAX_NS = 10000;
    localparam int T_RP_NS      = 80;
    localparam int T_RAH_NS     = 15;
    localparam int T_CP_NS      = 50;
    localparam int T_CWL_NS     = 50;
    localparam int T_SET_NS     = 20;
    localparam int T_REF_MS     = 4;
    localparam int T_PWRUP_US   = 100;

    // derived cycle counts
    localparam int C_RAC     = cyc_min(T_RAC_NS);
    localparam int C_CAC     = cyc_min(T_CAC_NS);
    localparam int C_RAS     = cyc_min(T_RAS_NS);
    localparam int C_RAS_MAX = cyc_max(T_RAS_MAX_NS);
    localparam int C_RP      = cyc_min(T_RP_NS);
    localparam int C_RAH     = cyc_min(T_RAH_NS);
    localparam int C_CP      = cyc_min(T_CP_NS);
    localparam int C_CWL     = cyc_min(T_CWL_NS);
    localparam int C_SET     = cyc_min(T_SET_NS);
    localparam int C_REF_INT = cyc_max(T_REF_MS * 1000000 / REF_ROWS);
    localparam int C_PWRUP   = cyc_min(T_PWRUP_US * 1000);
    localparam int C_MARGIN  = 32;

    // counter widths
    localparam int TMR_W  = 16;
    localparam int RCNT_W = 10;
    localparam int ICNT_W = 4;

    // controller states, one-hot
    typedef enum logic [11:0] {
        ST_BOOT  = 12'h001,
        ST_PWRUP = 12'h002,
        ST_IDLE  = 12'h004,
        ST_ASET  = 12'h008,
        ST_REF   = 12'h010,
        ST_RAS   = 12'h020,
        ST_CSET  = 12'h040,
        ST_CAS   = 12'h080,
        ST_WRT   = 12'h100,
        ST_CPRE  = 12'h200,
        ST_OPEN  = 12'h400,
        ST_RPRE  = 12'h800
    } drc_state_type;

    // split of a word address into its two halves
    function automatic logic [HALF_W-1:0] addr_row(input logic [ADDR_W-1:0] a);
        return a[ROW_LSB +: HALF_W];
    endfunction

    function automatic logic [HALF_W-1:0] addr_col(input logic [ADDR_W-1:0] a);
        return a[HALF_W-1:0];
    endfunction
endpackage

// file: design/drc_timer.sv
// Purpose: down-counter that times every strobe phase
// Assumes: value is the phase length minus one
// Notes:   done stays high at zero until the next load
module drc_timer
    import drc_pkg::*;
#(
    parameter int W = TMR_W
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // load wins over the running count
    always_comb begin
        next_cnt = cnt;
        if (load) begin
            next_cnt = value;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign done = (cnt == '0);
endmodule // drc_timer

// file: design/drc_refresh.sv
// Purpose: refresh interval timer and row pointer
// Assumes: ack pulses once for each row-strobe-only cycle issued
// Notes:   a tick landing with ack keeps pending set
module drc_refresh
    import drc_pkg::*;
#(
    parameter int INTERVAL = C_REF_INT,
    parameter int RW       = HALF_W
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // handshake with the sequencer
    input  wire logic          ack,
    output logic               pending,
    output logic [RW-1:0]      row
);
    logic [TMR_W-1:0] tick;
    logic [TMR_W-1:0] next_tick;
    logic             next_pending;
    logic [RW-1:0]    next_row;

    // spread the rows evenly over the refresh period
    always_comb begin
        next_tick    = (tick == '0) ? TMR_W'(INTERVAL - 1) : tick - 1'b1;
        next_pending = (pending & ~ack) | (tick == '0);
        next_row     = ack ? row + 1'b1 : row;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tick    <= '0;
            pending <= 1'b0;
            row     <= '0;
        end else begin
            tick    <= next_tick;
            pending <= next_pending;
            row     <= next_row;
        end
    end
endmodule // drc_refresh

// file: design/drc_host.sv
// Purpose: host sequencer driving a 64K x 1 strobe DRAM through its pins
// Assumes: pins are synchronous to mclk; dram_q is sampled only when valid
// Notes:   one request at a time; page mode keeps the row open on request
//
// Function
// - upper eight bits go out first, captured on the row strobe fall.
// - eight column bits follow on the same bus, captured on column strobe fall.
// - address is stable before each row and column strobe falls.
// - early write data is captured on the column strobe fall.
// - delayed or read-modify-write data is captured on write select fall.
// - all 256 rows are strobed within every 4 ms.
// - row-strobe-only cycle refreshes a row, no output driven.
// - page mode keeps the row strobe low over repeated column accesses.
// - wider pages share row strobe over devices, column strobe picks one; this host drives one device on a single cas_n.
// - after power-up, row strobe high for a while, then eight row cycles.
module drc_host
    import drc_pkg::*;
#(
    parameter int PWRUP_CYCLES = C_PWRUP
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_rmw,
    input  wire logic              req_page,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_wdata,
    // answer
    output logic                   rsp_valid,
    output logic                   rsp_rdata,
    output logic                   init_done,
    // memory pins
    output logic                   ras_n,
    output logic                   cas_n,
    output logic                   we_n,
    output logic [HALF_W-1:0]      multiplexed_address,
    output logic                   dram_d,
    input  wire logic              dram_q
);
    drc_state_type     state;
    drc_state_type     next_state;
    logic [HALF_W-1:0] row;
    logic [HALF_W-1:0] col;
    logic              op_write;
    logic              op_rmw;
    logic              op_page;
    logic              wdata;
    logic              pend;
    logic              do_ref;
    logic [ICNT_W-1:0] init_cnt;
    logic [RCNT_W-1:0] ras_cnt;
    logic [HALF_W-1:0] next_row;
    logic [HALF_W-1:0] next_col;
    logic              next_op_write;
    logic              next_op_rmw;
    logic              next_op_page;
    logic              next_wdata;
    logic              next_pend;
    logic              next_do_ref;
    logic [ICNT_W-1:0] next_init_cnt;
    logic [RCNT_W-1:0] next_ras_cnt;
    logic              next_ras_n;
    logic              next_cas_n;
    logic              next_we_n;
    logic [HALF_W-1:0] next_addr;
    logic              next_d;
    logic              next_ready;
    logic              next_rsp_valid;
    logic              next_rdata;
    logic              next_init_done;
    logic              take;
    logic              ras_ok;
    logic              near_limit;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_value;
    logic              tmr_done;
    logic              ref_pend;
    logic              ref_ack;
    logic [HALF_W-1:0] ref_row;

    ////////////////////////////////////////////////////////////////////////////
    // phase timer and refresh pacing
    drc_timer #(.W(TMR_W)) u_timer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .load  (tmr_load),
        .value (tmr_value),
        .done  (tmr_done)
    );

    drc_refresh #(.INTERVAL(C_REF_INT), .RW(HALF_W)) u_refresh (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ack     (ref_ack),
        .pending (ref_pend),
        .row     (ref_row)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request latch and row-low bookkeeping
    assign take       = req_valid & req_ready;
    assign ras_ok     = int'(ras_cnt) >= C_RAC;
    assign near_limit = int'(ras_cnt) >= C_RAS_MAX - C_MARGIN;

    always_comb begin
        next_row      = take ? addr_row(req_addr) : row;
        next_col      = take ? addr_col(req_addr) : col;
        next_op_write = take ? req_write : op_write;
        next_op_rmw   = take ? req_rmw : op_rmw;
        next_op_page  = take ? req_page : op_page;
        next_wdata    = take ? req_wdata : wdata;
        // saturate so a long page can never wrap to a short count
        next_ras_cnt  = ras_n ? '0 : (&ras_cnt ? ras_cnt : ras_cnt + 1'b1);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            row      <= '0;
            col      <= '0;
            op_write <= 1'b0;
            op_rmw   <= 1'b0;
            op_page  <= 1'b0;
            wdata    <= 1'b0;
            ras_cnt  <= '0;
        end else begin
            row      <= next_row;
            col      <= next_col;
            op_write <= next_op_write;
            op_rmw   <= next_op_rmw;
            op_page  <= next_op_page;
            wdata    <= next_wdata;
            ras_cnt  <= next_ras_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobe sequencer; every pin is a register so edges are glitch free
    always_comb begin
        logic fin;
        fin            = 1'b0;
        next_state     = state;
        next_ras_n     = ras_n;
        next_cas_n     = cas_n;
        next_we_n      = we_n;
        next_addr      = multiplexed_address;
        next_d         = dram_d;
        next_rsp_valid = 1'b0;
        next_rdata     = rsp_rdata;
        next_pend      = pend | take;
        next_do_ref    = do_ref;
        next_init_cnt  = init_cnt;
        next_init_done = init_done;
        tmr_load       = 1'b0;
        tmr_value      = '0;
        ref_ack        = 1'b0;
        unique case (state)
            ST_BOOT: begin
                tmr_load   = 1'b1;
                tmr_value  = TMR_W'(PWRUP_CYCLES - 1);
                next_state = ST_PWRUP;
            end
            ST_PWRUP: if (tmr_done) begin
                next_do_ref = 1'b1;
                tmr_load    = 1'b1;
                tmr_value   = TMR_W'(C_SET - 1);
                next_state  = ST_ASET;
            end
            ST_IDLE: if (take || ref_pend) begin
                next_do_ref = ~take;
                tmr_load    = 1'b1;
                tmr_value   = TMR_W'(C_SET - 1);
                next_state  = ST_ASET;
            end
            ST_ASET: begin
                next_addr = do_ref ? ref_row : row;
                if (tmr_done) begin
                    next_ras_n = 1'b0;
                    tmr_load   = 1'b1;
                    if (do_ref) begin
                        ref_ack    = 1'b1;
                        tmr_value  = TMR_W'(C_RAS - 1);
                        next_state = ST_REF;
                    end else begin
                        next_pend  = 1'b0;
                        tmr_value  = TMR_W'(C_RAH - 1);
                        next_state = ST_RAS;
                    end
                end
            end
            ST_REF: if (tmr_done) begin
                next_ras_n = 1'b1;
                tmr_load   = 1'b1;
                tmr_value  = TMR_W'(C_RP - 1);
                next_state = ST_RPRE;
                if (!init_done) begin
                    next_init_cnt  = init_cnt + 1'b1;
                    next_init_done = int'(init_cnt) == INIT_CYCLES - 1;
                end
            end
            ST_RAS: if (tmr_done) begin
                tmr_load   = 1'b1;
                tmr_value  = TMR_W'(C_SET - 1);
                next_state = ST_CSET;
            end
            ST_CSET: begin
                next_addr = col;
                next_we_n = ~(op_write & ~op_rmw);
                next_d    = wdata;
                if (tmr_done) begin
                    next_cas_n = 1'b0;
                    tmr_load   = 1'b1;
                    // one spare cycle: the sample edge must come after the
                    // column access time, never in the same instant
                    tmr_value  = TMR_W'(C_CAC);
                    next_state = ST_CAS;
                end
            end
            ST_CAS: if (tmr_done && ras_ok) begin
                if (!op_write || op_rmw) begin
                    next_rdata = dram_q;
                end
                if (op_rmw) begin
                    next_we_n  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = TMR_W'(C_CWL - 1);
                    next_state = ST_WRT;
                end else begin
                    fin = 1'b1;
                end
            end
            ST_WRT: if (tmr_done) begin
                fin = 1'b1;
            end
            ST_CPRE: if (tmr_done) begin
                next_state = ST_OPEN;
            end
            ST_OPEN: begin
                if (take && addr_row(req_addr) == row) begin
                    next_pend  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = TMR_W'(C_SET - 1);
                    next_state = ST_CSET;
                end else if (take || ref_pend || near_limit) begin
                    // a row miss closes the page and reopens on the new row
                    next_ras_n = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_value  = TMR_W'(C_RP - 1);
                    next_state = ST_RPRE;
                end
            end
            ST_RPRE: if (tmr_done) begin
                // refresh goes ahead of a waiting request
                next_do_ref = ref_pend | ~init_done;
                if (ref_pend || !init_done || pend) begin
                    tmr_load   = 1'b1;
                    tmr_value  = TMR_W'(C_SET - 1);
                    next_state = ST_ASET;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_BOOT;
        endcase
        if (fin) begin
            next_rsp_valid = 1'b1;
            next_cas_n     = 1'b1;
            next_we_n      = 1'b1;
            tmr_load       = 1'b1;
            if (op_page) begin
                tmr_value  = TMR_W'(C_CP - 1);
                next_state = ST_CPRE;
            end else begin
                next_ras_n = 1'b1;
                tmr_value  = TMR_W'(C_RP - 1);
                next_state = ST_RPRE;
            end
        end
        // ready only where a request can be taken next cycle
        next_ready = next_init_done & ~ref_pend & ~next_pend &
                     ((next_state == ST_IDLE) | ((next_state == ST_OPEN) & ~near_limit));
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state               <= ST_BOOT;
            ras_n               <= 1'b1;
            cas_n               <= 1'b1;
            we_n                <= 1'b1;
            multiplexed_address <= '0;
            dram_d              <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= 1'b0;
            pend                <= 1'b0;
            do_ref              <= 1'b0;
            init_cnt            <= '0;
            init_done           <= 1'b0;
        end else begin
            state               <= next_state;
            ras_n               <= next_ras_n;
            cas_n               <= next_cas_n;
            we_n                <= next_we_n;
            multiplexed_address <= next_addr;
            dram_d              <= next_d;
            req_ready           <= next_ready;
            rsp_valid           <= next_rsp_valid;
            rsp_rdata           <= next_rdata;
            pend                <= next_pend;
            do_ref              <= next_do_ref;
            init_cnt            <= next_init_cnt;
            init_done           <= next_init_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // refresh wait, counted only after init, since a long power-up wait
    // may legally keep the first refresh pending far longer
    localparam int REF_WAIT_MAX = 1100;
    logic [RCNT_W:0] ref_wait;
    logic [RCNT_W:0] next_ref_wait;

    always_comb begin
        next_ref_wait = (ref_pend && !ref_ack && init_done) ? ref_wait + 1'b1 : '0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_wait <= '0;
        end else begin
            ref_wait <= next_ref_wait;
        end
    end

    // checks on the pin sequence
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    row_addr_a: assert property ($fell(ras_n) |-> $stable(multiplexed_address)
        && multiplexed_address == (do_ref ? $past(ref_row) : row))
        else $error("row address moved at row strobe fall");
    col_addr_a: assert property ($fell(cas_n) |-> $stable(multiplexed_address) && !ras_n)
        else $error("column address moved at column strobe fall");
    early_data_a: assert property ($fell(cas_n) && !we_n |-> $stable(dram_d) ##1 $stable(dram_d))
        else $error("early write data not held around column strobe");
    rmw_data_a: assert property ($fell(we_n) && op_rmw |->
        !cas_n && $stable(dram_d) ##1 !we_n[*3])
        else $error("delayed write data or pulse wrong");
    cas_width_a: assert property ($fell(cas_n) |-> !cas_n[*7])
        else $error("column strobe low too short for access");
    read_sel_a: assert property (!cas_n && !op_write && !op_rmw |-> we_n)
        else $error("write select low in a read");
    ref_only_a: assert property (state == ST_REF |-> cas_n && we_n && !ras_n)
        else $error("column strobe active in refresh");
    ref_due_a: assert property (int'(ref_wait) < REF_WAIT_MAX)
        else $error("refresh not issued in time");
    page_open_a: assert property (state == ST_OPEN |-> !ras_n && cas_n)
        else $error("row not held open in page mode");
    init_seq_a: assert property ($fell(ras_n) && !init_done |-> do_ref)
        else $error("access before initialisation finished");
    read_ras_a: assert property ($rose(rsp_valid) && !op_write |->
        int'($past(ras_cnt)) >= C_RAC)
        else $error("read sampled before row access time");

    read_c: cover property (rsp_valid && !op_write && !op_rmw);
    write_c: cover property (rsp_valid && op_write && !op_rmw);
    rmw_c: cover property (rsp_valid && op_rmw);
    page_c: cover property (state == ST_OPEN ##1 state == ST_CSET);
    refresh_c: cover property (init_done && state == ST_REF);
endmodule // drc_host

// file: testbench/drc_dram_model.sv
// Purpose: behavioural 64K x 1 strobe DRAM facing the host sequencer
// Assumes: strobes, address and data come straight from the host pins
// Notes:   an output that is off shows the inverse of its last value
module drc_dram_model
    import drc_pkg::*;
(
    // strobes
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    // address and data
    input  wire logic [HALF_W-1:0] multiplexed_address,
    input  wire logic              dram_d,
    input  wire logic              slow,
    output logic                   dram_q
);
    timeunit 1ns;
    timeprecision 100ps;

    logic              mem [0:65535];
    logic [HALF_W-1:0] row;
    logic [HALF_W-1:0] col;
    logic [HALF_W-1:0] ref_row;
    logic              cas_seen = 1'b0;
    logic              opened   = 1'b0;
    realtime           t_ras    = 0;
    int                ras_only = 0;
    int                ras_acc  = 0;
    int                cas_cnt  = 0;

    initial dram_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // row half latched on the row strobe fall
    always @(negedge ras_n) begin
        row      = multiplexed_address;
        t_ras    = $realtime;
        cas_seen = 1'b0;
        opened   = 1'b1;
    end

    // a row period without any column strobe only refreshes that row
    always @(posedge ras_n) begin
        if (cas_seen) begin
            ras_acc++;
        end else if (opened) begin
            ras_only++;
            ref_row = row;
        end
    end

    // column half and early-write data latched on the column strobe fall;
    // a read drives only after both access times, so an early sample sees junk
    always @(negedge cas_n) begin
        col      = multiplexed_address;
        cas_seen = 1'b1;
        cas_cnt++;
        if (!we_n) begin
            mem[{row, col}] = dram_d;
        end else begin
            #(slow ? 85 : 70);
            if ($realtime < t_ras + 120) #(t_ras + 120 - $realtime);
            if (!cas_n) dram_q = mem[{row, col}];
        end
    end

    // late write select fall with the column strobe low writes the cell
    always @(negedge we_n) begin
        if (!cas_n) mem[{row, col}] = dram_d;
    end

    // unlatched output turns off with the column strobe
    always @(posedge cas_n) dram_q = ~dram_q;
endmodule // drc_dram_model

// file: testbench/tb_drc_host.sv
// Purpose: self-checking bench of the strobe DRAM host sequencer
// Assumes: power-up wait shortened to PWR cycles
// Notes:   data is judged through a behavioural memory on the pins
module tb_drc_host
    import drc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PWR = 20;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid, req_write, req_rmw, req_page, req_wdata, slow;
    logic [ADDR_W-1:0] req_addr;
    logic              req_ready, rsp_valid, rsp_rdata, init_done;
    logic              ras_n, cas_n, we_n, dram_d, dram_q, q;
    logic [HALF_W-1:0] multiplexed_address;
    logic [HALF_W-1:0] p_adr = '0;
    logic              p_ras = 1'b1;
    logic              p_cas = 1'b1;
    int                error_cnt = 0;
    int                cmp_count = 0;
    int                hi_run = 0;
    int                first_hi = -1;
    int                n, r0, c0, a0;
    logic [HALF_W-1:0] rr;
    logic [ADDR_W-1:0] adr [4] = '{16'h0000, 16'hFFFF, 16'h1234, 16'h3412};
    logic              dat [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #5 mclk = ~mclk;

    drc_host #(.PWRUP_CYCLES(PWR)) dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw), .req_page(req_page),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .multiplexed_address(multiplexed_address), .dram_d(dram_d),
        .dram_q(dram_q));
    drc_dram_model model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .slow(slow),
        .multiplexed_address(multiplexed_address), .dram_d(dram_d), .dram_q(dram_q));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one request held until taken, then wait for its answer
    task automatic access(input logic wr, rmw, pg, input logic [15:0] a, input logic d);
        int k;
        @(posedge mclk);
        #1 {req_valid, req_write, req_rmw, req_page, req_addr, req_wdata} = {1'b1, wr, rmw, pg, a, d};
        k = 0;
        do begin @(negedge mclk); k++; end while (req_ready !== 1'b1 && k < 3000);
        @(posedge mclk);
        #1 req_valid = 1'b0;
        k = 0;
        do begin @(negedge mclk); k++; end while (rsp_valid !== 1'b1 && k < 200);
        q = rsp_rdata;
        chk(k < 200, 1'b1);
    endtask

    task automatic wait_ref();
        r0 = model.ras_only;
        n = 0;
        do begin @(negedge mclk); n++; end while (model.ras_only == r0 && n < 2000);
    endtask

    // address must already stand at the edge before each strobe fall
    always @(negedge mclk) begin
        if (rst_n && ((p_ras && !ras_n) || (p_cas && !cas_n))) chk(multiplexed_address, p_adr);
        if (rst_n && first_hi < 0 && ras_n) hi_run++;
        if (rst_n && first_hi < 0 && !ras_n) first_hi = hi_run;
        {p_ras, p_cas, p_adr} = {ras_n, cas_n, multiplexed_address};
    end

    initial begin
        {req_valid, req_write, req_rmw, req_page, req_addr, req_wdata, slow} = '0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk({ras_n, cas_n, we_n, init_done, req_ready}, 5'b11100);
        @(posedge mclk);
        #1 rst_n = 1'b1;
        n = 0;
        do begin @(negedge mclk); n++; end while (init_done !== 1'b1 && n < 1000);
        chk({model.ras_only[7:0], model.cas_cnt[7:0]}, 16'h0800);
        chk(first_hi >= PWR, 1'b1);
        foreach (adr[i]) access(1'b1, 1'b0, 1'b0, adr[i], dat[i]);
        foreach (adr[i]) begin
            slow = i[0];
            access(1'b0, 1'b0, 1'b0, adr[i], ~dat[i]);
            chk(q, dat[i]);
        end
        access(1'b0, 1'b1, 1'b0, 16'h1234, 1'b0);
        chk(q, 1'b1);
        access(1'b0, 1'b0, 1'b0, 16'h1234, 1'b1);
        chk(q, 1'b0);
        wait_ref();
        rr = model.ref_row;
        c0 = model.cas_cnt;
        wait_ref();
        chk(n <= C_REF_INT + 2, 1'b1);
        chk({model.ref_row, model.cas_cnt[7:0]}, {rr + 8'h01, c0[7:0]});
        slow = 1'b0;
        a0 = model.ras_acc;
        access(1'b1, 1'b0, 1'b1, 16'h1256, 1'b1);
        access(1'b0, 1'b0, 1'b1, 16'h1234, 1'b1);
        chk(q, 1'b0);
        access(1'b0, 1'b0, 1'b0, 16'h1256, 1'b0);
        chk(q, 1'b1);
        chk(model.ras_acc - a0, 16'h0001);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        conclude();
    end
endmodule // tb_drc_host
